// ==== tmr_top.sv ====
// Our own choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/10ps
`include "tmr_map.svh"
module tmr_top (
  input  wire logic        i_sys_clk,
  input  wire logic        i_rst_n,
  input  wire logic        i_tmr_in,
  output logic             o_tmr_out,
  output logic             o_irq,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready
);
  import tmr_pkg::*;

  tmr_edge_if edge_bus ();

  tmr_edge_det i_tmr_edge_det (
    .i_sys_clk (i_sys_clk),
    .i_rst_n   (i_rst_n),
    .i_pin     (i_tmr_in),
    .edge_bus  (edge_bus.src)
  );

  logic [15:0]    count;
  logic [15:0]    reload;
  logic [7:0]     ctl;
  logic           irq_stat;
  logic           irq_mask;
  logic [6:0]     pre_cnt;
  logic           out_lvl;
  tmr_bus_state_t bstate;
  logic           aw_hold;
  logic           w_hold;
  logic [7:0]     aw_addr;
  logic [31:0]    w_data;
  logic [3:0]     w_strb;

  logic [15:0]    next_count;
  logic [15:0]    next_reload;
  logic [7:0]     next_ctl;
  logic           next_irq_stat;
  logic           next_irq_mask;
  logic [6:0]     next_pre_cnt;
  logic           next_out_lvl;
  tmr_bus_state_t next_bstate;
  logic           next_aw_hold;
  logic           next_w_hold;
  logic [7:0]     next_aw_addr;
  logic [31:0]    next_w_data;
  logic [3:0]     next_w_strb;
  logic           next_awready;
  logic           next_wready;
  logic           next_bvalid;
  logic [1:0]     next_bresp;
  logic           next_arready;
  logic           next_rvalid;
  logic [31:0]    next_rdata;
  logic [1:0]     next_rresp;
  logic           next_irq;
  logic           next_tmr_out;

  logic           enable;
  tmr_mode_t      mode;
  logic [2:0]     pre_sel;
  logic           step;
  logic           reload_hit;
  logic           do_write;
  logic           do_read;
  logic           wr_ok;
  logic [31:0]    rd_val;
  logic           rd_ok;
  logic           bus_idle;
  logic           aw_take;
  logic           w_take;
  logic           wr_busy;

  assign enable       = ctl[`TMR_CTL_EN_BIT];
  assign mode         = tmr_mode_t'(ctl[`TMR_CTL_MODE_BIT]);
  assign pre_sel      = ctl[`TMR_CTL_PRE_LSB +: 3];
  assign edge_bus.pol = ctl[`TMR_CTL_POL_BIT];

  always_comb begin
    // Prescale divisor is 2**pre_sel; counter mode ignores it entirely.
    if (mode == TMR_MODE_CNTR) begin
      step = enable & edge_bus.tick; // [RULE10] [RULE12]
    end else begin
      step = enable & (pre_cnt == ((7'h01 << pre_sel) - 7'h01)); // [RULE7] [RULE8] [RULE18]
    end
    reload_hit = step & (count == reload); // [RULE14] [RULE18]
  end

  always_comb begin
    bus_idle = (bstate == TMR_BUS_IDLE);
    aw_take  = i_awvalid && o_awready;
    w_take   = i_wvalid && o_wready;
    do_read  = i_arvalid && o_arready;
    // A write is applied only once both halves sit in the holding registers.
    do_write = bus_idle && aw_hold && w_hold;
    // Reads wait while any part of a write is in flight, which gives writes priority.
    wr_busy  = aw_hold || w_hold || i_awvalid || i_wvalid || o_awready || o_wready;
    next_aw_addr = aw_take ? i_awaddr : aw_addr;
    next_w_data  = w_take ? i_wdata : w_data;
    next_w_strb  = w_take ? i_wstrb : w_strb;
    next_aw_hold = do_write ? 1'b0 : (aw_hold | aw_take);
    next_w_hold  = do_write ? 1'b0 : (w_hold | w_take);
    // Each ready is a one-cycle pulse, so a valid that still stands is taken only once.
    next_awready = bus_idle && i_awvalid && !aw_hold && !o_awready && !o_arready;
    next_wready  = bus_idle && i_wvalid && !w_hold && !o_wready && !o_arready;
    next_arready = bus_idle && i_arvalid && !o_arready && !wr_busy;
    wr_ok = 1'b1;
    unique case (aw_addr)
      `TMR_OFF_CNT_HI, `TMR_OFF_CNT_LO, `TMR_OFF_RLD_HI, `TMR_OFF_RLD_LO,
      `TMR_OFF_CTL, `TMR_OFF_IRQ_STAT, `TMR_OFF_IRQ_MASK: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
    rd_ok  = 1'b1;
    rd_val = 32'h00000000;
    unique case (i_araddr)
      `TMR_OFF_CNT_HI:   rd_val = {24'h000000, count[15:8]};
      `TMR_OFF_CNT_LO:   rd_val = {24'h000000, count[7:0]};
      `TMR_OFF_RLD_HI:   rd_val = {24'h000000, reload[15:8]};
      `TMR_OFF_RLD_LO:   rd_val = {24'h000000, reload[7:0]};
      `TMR_OFF_CTL:      rd_val = {24'h000000, ctl};
      `TMR_OFF_IRQ_STAT: rd_val = {31'h00000000, irq_stat};
      `TMR_OFF_IRQ_MASK: rd_val = {31'h00000000, irq_mask};
      default:           rd_ok  = 1'b0;
    endcase
    next_bstate  = bstate;
    next_bvalid  = o_bvalid;
    next_bresp   = o_bresp;
    next_rvalid  = o_rvalid;
    next_rdata   = o_rdata;
    next_rresp   = o_rresp;
    unique case (bstate)
      TMR_BUS_IDLE: begin
        if (do_write) begin
          next_bstate = TMR_BUS_WRSP;
          next_bvalid = 1'b1;
          next_bresp  = wr_ok ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
        end else if (do_read) begin
          next_bstate  = TMR_BUS_RRSP;
          next_rvalid  = 1'b1;
          next_rdata   = rd_val;
          next_rresp   = rd_ok ? `TMR_RESP_OKAY : `TMR_RESP_SLVERR;
        end
      end
      TMR_BUS_WRSP: begin
        if (i_bready) begin
          next_bstate = TMR_BUS_IDLE;
          next_bvalid = 1'b0;
        end
      end
      TMR_BUS_RRSP: begin
        if (i_rready) begin
          next_bstate = TMR_BUS_IDLE;
          next_rvalid = 1'b0;
        end
      end
      default: next_bstate = TMR_BUS_IDLE;
    endcase
  end

  always_comb begin
    next_count    = count;
    next_reload   = reload;
    next_ctl      = ctl;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    next_out_lvl  = out_lvl;
    next_pre_cnt  = (enable && mode == TMR_MODE_CONT && !step) ? pre_cnt + 7'h01 : 7'h00;
    if (step) begin
      // Reload always restarts at 0001H, never at the written start value.
      next_count   = reload_hit ? `TMR_RST_COUNT : count + 16'h0001; // [RULE3] [RULE15] [RULE9]
      next_out_lvl = reload_hit ? ~out_lvl : out_lvl;
    end
    if (!enable) begin
      next_out_lvl = ctl[`TMR_CTL_OLVL_BIT]; // [RULE17]
    end
    if (do_write && w_strb[0]) begin
      unique case (aw_addr)
        `TMR_OFF_CNT_HI:   next_count[15:8] = w_data[7:0]; // [RULE2]
        `TMR_OFF_CNT_LO:   next_count[7:0]  = w_data[7:0]; // [RULE2]
        `TMR_OFF_RLD_HI:   next_reload[15:8] = w_data[7:0];
        `TMR_OFF_RLD_LO:   next_reload[7:0]  = w_data[7:0];
        `TMR_OFF_CTL:      next_ctl = w_data[7:0];
        `TMR_OFF_IRQ_STAT: next_irq_stat = irq_stat & ~w_data[0];
        `TMR_OFF_IRQ_MASK: next_irq_mask = w_data[0];
        default:           next_ctl = ctl;
      endcase
    end
    // A reload in the same cycle as a clear keeps the flag set.
    if (reload_hit) begin
      next_irq_stat = 1'b1; // [RULE14]
    end
    next_irq     = next_irq_stat & next_irq_mask;
    next_tmr_out = next_out_lvl;
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      count     <= `TMR_RST_COUNT;
      reload    <= `TMR_RST_RELOAD;
      ctl       <= `TMR_RST_CTL;
      irq_stat  <= 1'b0;
      irq_mask  <= 1'b0;
      pre_cnt   <= 7'h00;
      out_lvl   <= 1'b0;
      bstate    <= TMR_BUS_IDLE;
      aw_hold   <= 1'b0;
      w_hold    <= 1'b0;
      aw_addr   <= 8'h00;
      w_data    <= 32'h00000000;
      w_strb    <= 4'h0;
      o_awready <= 1'b0;
      o_wready  <= 1'b0;
      o_bvalid  <= 1'b0;
      o_bresp   <= 2'h0;
      o_arready <= 1'b0;
      o_rvalid  <= 1'b0;
      o_rdata   <= 32'h00000000;
      o_rresp   <= 2'h0;
      o_irq     <= 1'b0;
      o_tmr_out <= 1'b0;
    end else begin
      count     <= next_count;
      reload    <= next_reload;
      ctl       <= next_ctl;
      irq_stat  <= next_irq_stat;
      irq_mask  <= next_irq_mask;
      pre_cnt   <= next_pre_cnt;
      out_lvl   <= next_out_lvl;
      bstate    <= next_bstate;
      aw_hold   <= next_aw_hold;
      w_hold    <= next_w_hold;
      aw_addr   <= next_aw_addr;
      w_data    <= next_w_data;
      w_strb    <= next_w_strb;
      o_awready <= next_awready;
      o_wready  <= next_wready;
      o_bvalid  <= next_bvalid;
      o_bresp   <= next_bresp;
      o_arready <= next_arready;
      o_rvalid  <= next_rvalid;
      o_rdata   <= next_rdata;
      o_rresp   <= next_rresp;
      o_irq     <= next_irq;
      o_tmr_out <= next_tmr_out;
    end
  end
endmodule

// ==== tmr_map.svh ====
// Notes on behaviour
// RULE1: Software disables, picks mode, prescale, output level.
// RULE2: Written start count only affects first pass.
// RULE3: After first reload, counting restarts at 0001H.
// RULE4: Software writes reload value before enabling.
// RULE5: Control enable write starts counting.
// RULE6: Software routes pin to timer output.
// RULE7: Continuous mode counts prescaled system clock.
// RULE8: Period equals reload times prescale over clock.
// RULE9: Odd start count gives shorter first period.
// RULE10: Counter mode counts input pin transitions.
// RULE11: Polarity bit picks rising or falling edge.
// RULE12: Counter mode bypasses prescaler, one per edge.
// RULE13: Input frequency at most quarter system clock.
// RULE14: Reaching reload in counter mode raises interrupt.
// RULE15: Counter mode reloads 0001H and keeps counting.
// RULE16: Software enables interrupt before starting timer.
// RULE17: Output starts at configured initial level.
// RULE18: 16-bit count, one step per prescale tick.
`ifndef TMR_MAP_SVH
`define TMR_MAP_SVH
`define TMR_OFF_CNT_HI    8'h00
`define TMR_OFF_CNT_LO    8'h04
`define TMR_OFF_RLD_HI    8'h08
`define TMR_OFF_RLD_LO    8'h0C
`define TMR_OFF_CTL       8'h10
`define TMR_OFF_IRQ_STAT  8'h14
`define TMR_OFF_IRQ_MASK  8'h18
`define TMR_CTL_EN_BIT    7
`define TMR_CTL_POL_BIT   6
`define TMR_CTL_PRE_LSB   3
`define TMR_CTL_MODE_BIT  0
`define TMR_CTL_OLVL_BIT  1
`define TMR_RST_COUNT     16'h0001
`define TMR_RST_RELOAD    16'hFFFF
`define TMR_RST_CTL       8'h00
`define TMR_RESP_OKAY     2'h0
`define TMR_RESP_SLVERR   2'h2
`endif

// ==== tmr_pkg.sv ====
package tmr_pkg;
  typedef enum logic [0:0] {
    TMR_MODE_CONT = 1'b0,
    TMR_MODE_CNTR = 1'b1
  } tmr_mode_t;
  typedef enum logic [2:0] {
    TMR_BUS_IDLE = 3'b001,
    TMR_BUS_WRSP = 3'b010,
    TMR_BUS_RRSP = 3'b100
  } tmr_bus_state_t;
endpackage

// ==== tmr_edge_if.sv ====
`timescale 1ns/10ps
interface tmr_edge_if;
  logic pol;
  logic tick;
  modport src (input pol, output tick);
  modport dst (output pol, input tick);
endinterface

// ==== tmr_edge_det.sv ====
`timescale 1ns/10ps
module tmr_edge_det (
  input  wire logic i_sys_clk,
  input  wire logic i_rst_n,
  input  wire logic i_pin,
  tmr_edge_if.src   edge_bus
);
  import tmr_pkg::*;
  logic sync1;
  logic sync2;
  logic prev;
  logic next_sync1;
  logic next_sync2;
  logic next_prev;
  logic next_tick;

  always_comb begin
    next_sync1 = i_pin;
    next_sync2 = sync1;
    next_prev  = sync2;
    // Only the second stage and its delayed copy feed the edge compare.
    next_tick  = edge_bus.pol ? (sync2 & ~prev) : (~sync2 & prev); // [RULE10] [RULE11]
  end

  always_ff @(posedge i_sys_clk) begin
    if (!i_rst_n) begin
      sync1         <= 1'b0;
      sync2         <= 1'b0;
      prev          <= 1'b0;
      edge_bus.tick <= 1'b0;
    end else begin
      sync1         <= next_sync1;
      sync2         <= next_sync2;
      prev          <= next_prev;
      edge_bus.tick <= next_tick;
    end
  end
endmodule

// ==== tmr_top_props.sv ====
`timescale 1ns/10ps
module tmr_top_props (
  input wire logic        i_sys_clk,
  input wire logic        i_rst_n,
  input wire logic        i_tmr_in,
  input wire logic        o_tmr_out,
  input wire logic        o_irq,
  input wire logic [7:0]  i_awaddr,
  input wire logic        i_awvalid,
  input wire logic [31:0] i_wdata,
  input wire logic        i_wvalid,
  input wire logic        o_bvalid,
  input wire logic        i_bready
);
  import tmr_pkg::*;
  logic [7:0]  ctl;
  logic [7:0]  adr;
  logic [7:0]  dat;
  logic [15:0] rld;
  logic [15:0] ne;
  logic [23:0] gap;
  logic [3:0]  wa;
  logic [3:0]  ea;
  logic        msk;
  logic        q;
  logic        p;
  logic        arm;
  wire c = o_bvalid && i_bready;
  wire tog = o_tmr_out != q;
  wire rw = i_awvalid || i_wvalid || wa < 4'h5;
  wire se = ctl[6] ? (i_tmr_in && !p) : (!i_tmr_in && p);
  // Shadows follow committed writes; checks pause near a write since the design
  // applies it a cycle or two before the shadow does.
  always_ff @(posedge i_sys_clk) begin
    q <= o_tmr_out;
    p <= i_tmr_in;
    gap <= tog ? 24'h000001 : gap + 24'h000001;
    ne <= tog ? {15'h0000, se} : ne + {15'h0000, se};
    ea <= se ? 4'h0 : (ea == 4'hF ? ea : ea + 4'h1);
    if (i_awvalid && i_wvalid) begin
      adr <= i_awaddr;
      dat <= i_wdata[7:0];
    end
    if (!i_rst_n) begin
      ctl <= 8'h00;
      rld <= 16'hFFFF;
      msk <= 1'b0;
      wa <= 4'hF;
      arm <= 1'b0;
    end else begin
      wa <= (i_awvalid || i_wvalid) ? 4'h0 : (wa == 4'hF ? wa : wa + 4'h1);
      arm <= rw ? 1'b0 : (tog ? 1'b1 : arm);
      if (c && adr == 8'h10) ctl <= dat;
      if (c && adr == 8'h08) rld[15:8] <= dat;
      if (c && adr == 8'h0C) rld[7:0] <= dat;
      if (c && adr == 8'h18) msk <= dat[0];
    end
  end
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rst_n);
  property p_idle; !ctl[7] && !rw |-> o_tmr_out == ctl[1]; endproperty
  a_idle: assert property (p_idle) else $error("output not at idle level");
  property p_quiet; !ctl[7] && !rw |-> !tog; endproperty
  a_quiet: assert property (p_quiet) else $error("reload while disabled");
  property p_mask; !msk && !rw |-> !o_irq; endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt seen");
  property p_cause; $rose(o_irq) |-> tog || rw; endproperty
  a_cause: assert property (p_cause) else $error("interrupt without reload");
  property p_hold; o_irq && !rw |=> o_irq; endproperty
  a_hold: assert property (p_hold) else $error("interrupt dropped alone");
  property p_per; arm && tog && ctl == (ctl & 8'hBE) |-> gap == ({8'h00, rld} << ctl[5:3]);
  endproperty
  a_per: assert property (p_per) else $error("wrong continuous period");
  property p_cper; arm && tog && ctl[7] && ctl[0] |-> ne == rld; endproperty
  a_cper: assert property (p_cper) else $error("wrong edge count");
  property p_edge; tog && ctl[7] && ctl[0] && !rw |-> ea inside {[2:5]}; endproperty
  a_edge: assert property (p_edge) else $error("reload not after chosen edge");
endmodule
bind tmr_top tmr_top_props i_props (.*);

// ==== tmr_pin_model.sv ====
`timescale 1ns/10ps
module tmr_pin_model (
  input  wire logic i_sys_clk,
  input  wire logic i_run,
  output logic      o_pin
);
  logic [1:0] ph;
  initial begin
    o_pin = 1'b0;
    ph = 2'h0;
  end
  // Four cycles per half period keeps the pin under a quarter of the clock.
  always @(posedge i_sys_clk) begin
    if (i_run) begin
      ph <= ph + 2'h1;
      if (ph == 2'h3) o_pin <= !o_pin;
    end
  end
endmodule

// ==== tmr_top_tb.sv ====
`timescale 1ns/10ps
module tmr_top_tb;
  import tmr_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [1:0] r;} tmr_row_t;
  logic clk, rst_n, pin, run, out, irq, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  int          err_count, tests_run, n;
  tmr_row_t rows [14] = '{'{0,8'h00,8'h00,0}, '{0,8'h04,8'h01,0}, '{0,8'h08,8'hFF,0},
    '{0,8'h0C,8'hFF,0}, '{0,8'h10,8'h00,0}, '{0,8'h14,8'h00,0}, '{0,8'h18,8'h00,0},
    '{0,8'h1C,8'h00,2}, '{1,8'h1C,8'h55,2}, '{1,8'h04,8'h7E,0}, '{0,8'h04,8'h7E,0},
    '{1,8'h14,8'h01,0}, '{0,8'h14,8'h00,0}, '{1,8'h18,8'h01,0}};
  tmr_top i_tmr_top (.i_sys_clk(clk), .i_rst_n(rst_n), .i_tmr_in(pin), .o_tmr_out(out),
    .o_irq(irq), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
    .i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
    .o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
    .i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
    .o_rvalid(rvalid), .i_rready(rready));
  tmr_pin_model i_tmr_pin_model (.i_sys_clk(clk), .i_run(run), .o_pin(pin));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    int k;
    k = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, v};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid && k < 50);
    bready <= 1'b0;
    r = bresp;
    chk(k < 50, 1);
  endtask
  task automatic rd(input logic [7:0] a);
    int k;
    k = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      k++;
      if (arready) arvalid <= 1'b0;
    end while (!rvalid && k < 50);
    rready <= 1'b0;
    d = rdata;
    r = rresp;
    chk(k < 50, 1);
  endtask
  // Counts edges until the output flips, or gives up at the limit.
  task automatic wtog(input int lim);
    logic v;
    v = out;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (out === v && n < lim);
  endtask
  task end_sim;
    if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (5000) @(posedge clk);
    err_count++;
    end_sim;
  end
  initial begin
    {rst_n, run, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb, err_count, tests_run} = '0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    wstrb <= 4'hF;
    foreach (rows[k]) begin
      if (rows[k].w) wr(rows[k].a, rows[k].d);
      else rd(rows[k].a);
      if (!rows[k].w) chk(d, {24'h000000, rows[k].d});
      chk(r, rows[k].r);
    end
    wr(8'h10, 8'h0A);
    repeat (3) @(posedge clk);
    chk(out, 1);
    wr(8'h00, 8'h00);
    wr(8'h04, 8'h05);
    wr(8'h08, 8'h00);
    wr(8'h0C, 8'h0A);
    // The pin keeps toggling so a count taken from it would spoil the period.
    run <= 1'b1;
    wr(8'h10, 8'h8A);
    wtog(100);
    chk(n >= 9 && n <= 14, 1);
    wtog(100);
    chk(n, 20);
    chk(irq, 1);
    wr(8'h18, 8'h00);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    wr(8'h18, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 1);
    wr(8'h10, 8'h0A);
    wr(8'h14, 8'h01);
    repeat (2) @(posedge clk);
    chk(irq, 0);
    chk(out, 1);
    wr(8'h0C, 8'h03);
    wr(8'h04, 8'h01);
    wr(8'h10, 8'hF9);
    wtog(200);
    wtog(200);
    chk(n, 24);
    wr(8'h10, 8'hB9);
    wtog(200);
    wtog(200);
    chk(n, 24);
    run <= 1'b0;
    repeat (10) @(posedge clk);
    wtog(100);
    chk(n, 100);
    end_sim;
  end
endmodule
